// ---- include/pllcl_pkg.sv ----
// Purpose: Constants and state types for the frequency synthesizer control block.
// Assumes: Byte-wide special function register bus, 100 MHz core_clk.
// Notes:   Every offset, field position, reset value and timing count is named here once.
// Contract
// - Lock indicator reads in control bit 4.
// - Bit 2 selects internal or external reference.
// - Loop held in reset while enable clear.
// - Bit 0 switches the bias generator.
// - Control and divider upper bits read zero.
// - Pre-divider zero means divide by 32.
// - Multiplier zero means factor 256.
// - Output equals reference times multiplier over divider.
// - Filter register upper two bits read zero.
package pllcl_pkg;

    localparam logic [7:0] PLLCL_OFS_CONTROL = 8'h89;
    localparam logic [7:0] PLLCL_OFS_DIVIDER = 8'h8d;
    localparam logic [7:0] PLLCL_OFS_MULT    = 8'h8e;
    localparam logic [7:0] PLLCL_OFS_FILTER  = 8'h8f;

    localparam logic [7:0] PLLCL_RST_CONTROL = 8'h00;
    localparam logic [4:0] PLLCL_RST_DIVIDER = 5'h01;
    localparam logic [7:0] PLLCL_RST_MULT    = 8'h01;
    localparam logic [5:0] PLLCL_RST_FILTER  = 6'h31;

    localparam int PLLCL_BIT_LOCK  = 4;
    localparam int PLLCL_BIT_SRC   = 2;
    localparam int PLLCL_BIT_EN    = 1;
    localparam int PLLCL_BIT_PWR   = 0;
    localparam int PLLCL_DIV_W     = 5;
    localparam int PLLCL_FLT_W     = 6;
    localparam int PLLCL_ICO_LSB   = 4;
    localparam int PLLCL_LP_MSB    = 3;

    localparam logic [5:0] PLLCL_DIV_ZERO_VAL  = 6'h20;
    localparam logic [8:0] PLLCL_MULT_ZERO_VAL = 9'h100;

    localparam int PLLCL_CLK_MHZ         = 100;
    localparam int PLLCL_LOCK_DELAY_US   = 50;
    localparam int PLLCL_LOCK_CYCLES     = PLLCL_LOCK_DELAY_US * PLLCL_CLK_MHZ;
    localparam int PLLCL_LOCK_CNT_W      = 16;

    typedef struct packed {
        logic                   src_ext;
        logic                   loop_en;
        logic                   bias_en;
        logic [PLLCL_DIV_W-1:0] predivide;
        logic [7:0]             multiplier;
        logic [PLLCL_FLT_W-1:0] filter;
        logic [7:0]             rdata;
        logic [5:0]             div_eff;
        logic [8:0]             mul_eff;
        logic                   loop_reset;
        logic [31:0]            freq_khz;
    } pllcl_state_s;

    typedef enum logic [1:0] {
        PLLCL_LK_OFF   = 2'b00,
        PLLCL_LK_WAIT  = 2'b01,
        PLLCL_LK_LOCK  = 2'b10
    } pllcl_lock_e;

    typedef struct packed {
        pllcl_lock_e                 st;
        logic [PLLCL_LOCK_CNT_W-1:0] cnt;
        logic                        locked;
    } pllcl_timer_s;

endpackage : pllcl_pkg

// ---- include/pllcl_lock_if.sv ----
// Purpose: Carries the arm request and lock answer between control and lock timer.
// Assumes: Both ends run on core_clk.
// Notes:   Arm is a level; dropping it must clear lock in the same edge.
`timescale 1ns/10ps
interface pllcl_lock_if;
    logic arm;
    logic locked;
    modport ctrl  (output arm, input locked);
    modport timer (input arm, output locked);
endinterface : pllcl_lock_if

// ---- core/pllcl_lock_timer.sv ----
// Purpose: Models the analog loop settling as a fixed lock delay.
// Assumes: Arm is high only while bias and loop enable are both set.
// Notes:   A new arm after a drop restarts the full delay.
`timescale 1ns/10ps
module pllcl_lock_timer #(
    parameter int LOCK_DELAY_CYCLES = pllcl_pkg::PLLCL_LOCK_CYCLES
) (
    input  wire logic  core_clk,
    input  wire logic  rst,
    pllcl_lock_if.timer lk
);
    import pllcl_pkg::*;

    localparam logic [PLLCL_LOCK_CNT_W-1:0] LAST = PLLCL_LOCK_CNT_W'(LOCK_DELAY_CYCLES - 1);

    pllcl_timer_s t_q;
    pllcl_timer_s t_d;

    always_comb begin
        t_d = t_q;
        case (t_q.st)
            PLLCL_LK_OFF: begin
                t_d.cnt = '0;
                if (lk.arm) begin
                    t_d.st = PLLCL_LK_WAIT;
                end
            end
            PLLCL_LK_WAIT: begin
                t_d.cnt = t_q.cnt + 1'b1;
                if (t_q.cnt >= LAST) begin
                    t_d.st = PLLCL_LK_LOCK;
                end
            end
            PLLCL_LK_LOCK: begin
                t_d.cnt = t_q.cnt;
            end
            default: begin
                t_d.st = PLLCL_LK_OFF;
            end
        endcase
        // Losing arm wins over every state so lock never lingers.
        if (!lk.arm) begin
            t_d.st  = PLLCL_LK_OFF;
            t_d.cnt = '0;
        end
        t_d.locked = (t_d.st == PLLCL_LK_LOCK);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            t_q <= '{st: PLLCL_LK_OFF, cnt: '0, locked: 1'b0};
        end else begin
            t_q <= t_d;
        end
    end

    assign lk.locked = t_q.locked;

endmodule : pllcl_lock_timer

// ---- core/pllcl_top.sv ----
// Purpose: Register file and control outputs of the frequency synthesizer.
// Assumes: Register strobes are synchronous to core_clk; one access per cycle.
// Notes:   The analog loop is replaced by a lock delay and a numeric frequency model.
//          Range and filter selections are stored and passed on, never checked against
//          the programmed ratio; keeping them consistent is left to software.
`timescale 1ns/10ps
module pllcl_top #(
    parameter int LOCK_DELAY_CYCLES = pllcl_pkg::PLLCL_LOCK_CYCLES
) (
    input  wire logic                               core_clk,
    input  wire logic                               rst,
    // Register bus.
    input  wire logic                               sfr_page_sel,
    input  wire logic [7:0]                         sfr_addr,
    input  wire logic                               sfr_wr,
    input  wire logic                               sfr_rd,
    input  wire logic [7:0]                         sfr_wdata,
    output logic      [7:0]                         sfr_rdata,
    // Reference frequencies of the numeric model.
    input  wire logic [31:0]                        int_ref_khz,
    input  wire logic [31:0]                        ext_ref_khz,
    // Synthesizer controls, all held in flip-flops.
    output logic                                    ref_source_select,
    output logic                                    bias_power_enable,
    output logic                                    loop_enable,
    output logic                                    loop_reset,
    output logic      [5:0]                         ref_divisor,
    output logic      [8:0]                         mult_factor,
    output logic      [1:0]                         osc_range_select,
    output logic      [3:0]                         loop_filter_select,
    output logic      [31:0]                        synth_freq_khz,
    // Status.
    output logic                                    lock_indicator
);
    import pllcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State and lock timer.

    pllcl_state_s s_q;
    pllcl_state_s s_d;
    logic         lock_q;
    logic         lock_d;

    // A new arm always restarts the lock delay from zero.
    pllcl_lock_if lk ();

    pllcl_lock_timer #(
        .LOCK_DELAY_CYCLES (LOCK_DELAY_CYCLES)
    ) u_lock_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .lk       (lk)
    );

    // The loop only runs when bias and enable are both on, whatever order software used.
    assign lk.arm = s_q.loop_en & s_q.bias_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    // Every access needs the page select; the address alone also matches other pages.
    logic hit_ctl;
    logic hit_div;
    logic hit_mul;
    logic hit_flt;

    always_comb begin
        hit_ctl = sfr_page_sel && (sfr_addr == PLLCL_OFS_CONTROL);
        hit_div = sfr_page_sel && (sfr_addr == PLLCL_OFS_DIVIDER);
        hit_mul = sfr_page_sel && (sfr_addr == PLLCL_OFS_MULT);
        hit_flt = sfr_page_sel && (sfr_addr == PLLCL_OFS_FILTER);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write fields and read images.
    // Bit positions stay here, out of the next-state logic, so a moved field is one edit.

    logic                   wr_src_ext;
    logic                   wr_loop_en;
    logic                   wr_bias_en;
    logic [PLLCL_DIV_W-1:0] wr_predivide;
    logic [PLLCL_FLT_W-1:0] wr_filter;
    logic [7:0]             img_ctl;
    logic [7:0]             img_div;
    logic [7:0]             img_flt;
    logic [7:0]             img_sel;

    always_comb begin
        wr_src_ext   = sfr_wdata[PLLCL_BIT_SRC];
        wr_loop_en   = sfr_wdata[PLLCL_BIT_EN];
        wr_bias_en   = sfr_wdata[PLLCL_BIT_PWR];
        wr_predivide = sfr_wdata[PLLCL_DIV_W-1:0];
        wr_filter    = sfr_wdata[PLLCL_FLT_W-1:0];

        // Reserved bit 3 and unused bits 7:5 read as zero.
        img_ctl                 = 8'h00;
        img_ctl[PLLCL_BIT_LOCK] = lock_q;
        img_ctl[PLLCL_BIT_SRC]  = s_q.src_ext;
        img_ctl[PLLCL_BIT_EN]   = s_q.loop_en;
        img_ctl[PLLCL_BIT_PWR]  = s_q.bias_en;
        img_div                 = {3'h0, s_q.predivide};
        img_flt                 = {2'h0, s_q.filter};

        // A read that hits nothing, or comes while the page is away, returns zero.
        if (hit_ctl) begin
            img_sel = img_ctl;
        end else if (hit_div) begin
            img_sel = img_div;
        end else if (hit_mul) begin
            img_sel = s_q.multiplier;
        end else if (hit_flt) begin
            img_sel = img_flt;
        end else begin
            img_sel = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    // The product is 41 bits: a 32-bit reference times a 9-bit factor of up to 256.
    logic [31:0] ref_khz;
    logic [40:0] product;
    logic [40:0] quotient;

    always_comb begin
        s_d     = s_q;
        ref_khz = 32'h0;
        product = 41'h0;
        quotient = 41'h0;

        // Only the stored bits of each register take write data; the rest are dropped here.
        if (sfr_wr && hit_ctl) begin
            // Bit 3 is reserved and bit 4 is status, so neither is stored.
            s_d.src_ext = wr_src_ext;
            s_d.loop_en = wr_loop_en;
            s_d.bias_en = wr_bias_en;
        end
        if (sfr_wr && hit_div) begin
            s_d.predivide = wr_predivide;
        end
        if (sfr_wr && hit_mul) begin
            s_d.multiplier = sfr_wdata;
        end
        if (sfr_wr && hit_flt) begin
            s_d.filter = wr_filter;
        end

        // Read data is captured on the read strobe and held until the next read.
        // The image comes from the stored state, so a write in the same cycle reads old.
        if (sfr_rd) begin
            s_d.rdata = img_sel;
        end

        // Effective ratio from the values that will be stored this edge.
        if (s_d.predivide == '0) begin
            s_d.div_eff = PLLCL_DIV_ZERO_VAL;
        end else begin
            s_d.div_eff = {1'b0, s_d.predivide};
        end
        if (s_d.multiplier == 8'h00) begin
            s_d.mul_eff = PLLCL_MULT_ZERO_VAL;
        end else begin
            s_d.mul_eff = {1'b0, s_d.multiplier};
        end

        // Held in reset unless both bias and enable stand after this edge.
        s_d.loop_reset = ~(s_d.loop_en & s_d.bias_en);

        // Frequency model, zero while the loop is held in reset.
        ref_khz = s_d.src_ext ? ext_ref_khz : int_ref_khz;
        // Integer division truncates, so a ratio that does not divide evenly reads low.
        product = 41'(ref_khz) * 41'(s_d.mul_eff);
        quotient = product / 41'(s_d.div_eff);
        if (s_d.loop_reset) begin
            s_d.freq_khz = 32'h0;
        end else begin
            s_d.freq_khz = quotient[31:0];
        end

        lock_d = lk.locked;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Every field is reset by name so that the reset image is plain to read.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q.src_ext    <= PLLCL_RST_CONTROL[PLLCL_BIT_SRC];
            s_q.loop_en    <= PLLCL_RST_CONTROL[PLLCL_BIT_EN];
            s_q.bias_en    <= PLLCL_RST_CONTROL[PLLCL_BIT_PWR];
            s_q.predivide  <= PLLCL_RST_DIVIDER;
            s_q.multiplier <= PLLCL_RST_MULT;
            s_q.filter     <= PLLCL_RST_FILTER;
            s_q.rdata      <= 8'h00;
            s_q.div_eff    <= {1'b0, PLLCL_RST_DIVIDER};
            s_q.mul_eff    <= {1'b0, PLLCL_RST_MULT};
            s_q.loop_reset <= 1'b1;
            s_q.freq_khz   <= 32'h0;
            lock_q         <= 1'b0;
        end else begin
            s_q    <= s_d;
            lock_q <= lock_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    assign sfr_rdata          = s_q.rdata;
    assign ref_source_select  = s_q.src_ext;
    assign bias_power_enable  = s_q.bias_en;
    assign loop_enable        = s_q.loop_en;
    assign loop_reset         = s_q.loop_reset;
    // Divisor and factor are shown after the zero codes have been mapped.
    assign ref_divisor        = s_q.div_eff;
    assign mult_factor        = s_q.mul_eff;
    // Range and filter are passed on untouched; choosing them right is up to software.
    assign osc_range_select   = s_q.filter[PLLCL_FLT_W-1:PLLCL_ICO_LSB];
    assign loop_filter_select = s_q.filter[PLLCL_LP_MSB:0];
    assign synth_freq_khz     = s_q.freq_khz;
    // Lock passes one more flop here, so status leaves from this module's own register.
    assign lock_indicator     = lock_q;

endmodule : pllcl_top

// ---- tb/pllcl_top_asserts.sv ----
// Purpose: Port checks for the synthesizer control block.
// Assumes: One clock domain with a synchronous rst.
// Notes:   Lock timing is bounded by a run counter.
`timescale 1ns/10ps
module pllcl_top_asserts #(
    parameter int LOCK_DELAY_CYCLES = 8
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       sfr_page_sel,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       ref_source_select,
    input wire logic       bias_power_enable,
    input wire logic       loop_enable,
    input wire logic       loop_reset,
    input wire logic [5:0] ref_divisor,
    input wire logic [8:0] mult_factor,
    input wire logic       lock_indicator
);
    import pllcl_pkg::*;
    localparam int LK_HI = LOCK_DELAY_CYCLES + 5;
    wire logic  arm = loop_enable && bias_power_enable;
    logic [15:0] run_q;
    // Saturates so that a long lock never wraps back to zero; wide enough for the full delay.
    always_ff @(posedge core_clk) begin
        if (rst || !arm) run_q <= 16'h0000;
        else if (run_q != 16'hffff) run_q <= run_q + 16'h0001;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_wr(a);
        sfr_page_sel && sfr_wr && sfr_addr == a;
    endsequence
    sequence s_off;
        !arm [*3];
    endsequence
    ctl_write_a: assert property (s_wr(PLLCL_OFS_CONTROL) |=>
        {ref_source_select, loop_enable, bias_power_enable} == $past(sfr_wdata[2:0])) else $error("control write");
    div_write_a: assert property (s_wr(PLLCL_OFS_DIVIDER) |=>
        ref_divisor == ($past(sfr_wdata[4:0]) == 5'h00 ? 6'h20 : {1'b0, $past(sfr_wdata[4:0])})) else $error("divisor");
    mul_write_a: assert property (s_wr(PLLCL_OFS_MULT) |=>
        mult_factor == ($past(sfr_wdata) == 8'h00 ? 9'h100 : {1'b0, $past(sfr_wdata)})) else $error("multiplier");
    ctl_read_a: assert property (sfr_page_sel && sfr_rd && sfr_addr == PLLCL_OFS_CONTROL |=>
        sfr_rdata == {3'h0, $past(lock_indicator), 1'b0, $past({ref_source_select, loop_enable, bias_power_enable})})
        else $error("control read");
    loop_reset_a: assert property (loop_reset == !arm) else $error("loop reset");
    lock_rise_a: assert property ($rose(lock_indicator) |->
        run_q >= LOCK_DELAY_CYCLES) else $error("early lock");
    lock_late_a: assert property (run_q == LK_HI |-> lock_indicator) else $error("late lock");
    lock_drop_a: assert property (s_off |-> !lock_indicator) else $error("lock held");
endmodule : pllcl_top_asserts

bind pllcl_top pllcl_top_asserts #(.LOCK_DELAY_CYCLES(LOCK_DELAY_CYCLES)) u_asserts (.*);

// ---- tb/test_pll_config_and_lock_control.sv ----
// Purpose: Self-checking bench for the synthesizer control block.
// Assumes: Lock delay cut to LD cycles; references small enough not to overflow.
// Notes:   Corner and random register traffic, then two lock cycles.
`timescale 1ns/10ps
module test_pll_config_and_lock_control;
    import pllcl_pkg::*;
    localparam int LD = 8;
    logic core_clk = 1'b0, rst = 1'b1, sfr_page_sel = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic ref_source_select, bias_power_enable, loop_enable, loop_reset, lock_indicator;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, ctl_m, div_m, mul_m, flt_m;
    logic [31:0] int_ref_khz = 32'h5fb4, ext_ref_khz = 32'h2ee0, synth_freq_khz, seed = 32'h7c41;
    logic [5:0] ref_divisor;
    logic [8:0] mult_factor;
    logic [1:0] osc_range_select;
    logic [3:0] loop_filter_select;
    logic [7:0] regs [4] = '{PLLCL_OFS_CONTROL, PLLCL_OFS_DIVIDER, PLLCL_OFS_MULT, PLLCL_OFS_FILTER};
    int errors = 0, checks_done = 0, cyc = 0, n;

    pllcl_top #(.LOCK_DELAY_CYCLES(LD)) u_dut (.core_clk, .rst, .sfr_page_sel, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .int_ref_khz, .ext_ref_khz, .ref_source_select, .bias_power_enable,
        .loop_enable, .loop_reset, .ref_divisor, .mult_factor, .osc_range_select, .loop_filter_select,
        .synth_freq_khz, .lock_indicator);

    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] eff(input logic [31:0] v, input logic [31:0] z);
        return v == 32'h0 ? z : v;
    endfunction : eff
    function automatic logic [31:0] fq();
        return (ctl_m[2] ? ext_ref_khz : int_ref_khz) * eff(mul_m, 32'h100) / eff(div_m[4:0], 32'h20);
    endfunction : fq
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Read data is taken one edge after the strobe, when it has settled.
    task automatic bus(input logic s, input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        sfr_page_sel <= s;
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= w;
        sfr_rd <= !w;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        #1;
    endtask : bus
    task automatic w(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, 1'b1, a, v);
        if (a == PLLCL_OFS_CONTROL) ctl_m = v;
        if (a == PLLCL_OFS_DIVIDER) div_m = v;
        if (a == PLLCL_OFS_MULT) mul_m = v;
        if (a == PLLCL_OFS_FILTER) flt_m = v;
    endtask : w
    task automatic check_all(input logic lk);
        bus(1'b1, 1'b0, PLLCL_OFS_CONTROL, 8'h00);
        chk("control", sfr_rdata, {3'b000, lk, 1'b0, ctl_m[2:0]});
        bus(1'b1, 1'b0, PLLCL_OFS_DIVIDER, 8'h00);
        chk("divider", sfr_rdata, div_m[4:0]);
        bus(1'b1, 1'b0, PLLCL_OFS_MULT, 8'h00);
        chk("multiplier", sfr_rdata, mul_m);
        bus(1'b1, 1'b0, PLLCL_OFS_FILTER, 8'h00);
        chk("filter", sfr_rdata, flt_m[5:0]);
        chk("divisor", ref_divisor, eff(div_m[4:0], 32'h20));
        chk("factor", mult_factor, eff(mul_m, 32'h100));
        chk("range", {osc_range_select, loop_filter_select}, flt_m[5:0]);
        chk("pins", {ref_source_select, loop_enable, bias_power_enable, loop_reset},
            {ctl_m[2:0], ~&ctl_m[1:0]});
        chk("lock", lock_indicator, lk);
        chk("freq", synth_freq_khz, &ctl_m[1:0] ? fq() : 32'h0);
    endtask : check_all
    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        ctl_m = 8'h00;
        div_m = 8'h01;
        mul_m = 8'h01;
        flt_m = 8'h31;
    endtask : do_reset
    // Counts the edges from the arming write until lock reads high.
    task automatic lock_wait();
        n = 0;
        while (lock_indicator !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("lock wait", n, LD + 2);
    endtask : lock_wait
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        check_all(1'b0);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            w(PLLCL_OFS_DIVIDER, i ? 8'h1f : 8'he0);
            w(PLLCL_OFS_MULT, i ? 8'hff : 8'h00);
            w(PLLCL_OFS_FILTER, i ? 8'h00 : 8'hff);
            w(PLLCL_OFS_CONTROL, i ? 8'h04 : 8'hf1);
            check_all(1'b0);
        end
        for (int i = 0; i < 24; i++) begin
            n = xs();
            w(regs[n[9:8]], n[9:8] == 2'd0 ? n[7:0] & 8'hf5 : n[7:0]);
            check_all(1'b0);
        end
        w(8'h8a, 8'hff);
        bus(1'b1, 1'b0, 8'h8a, 8'h00);
        chk("unmapped", sfr_rdata, 32'h0);
        bus(1'b0, 1'b1, PLLCL_OFS_MULT, 8'h5a);
        bus(1'b0, 1'b0, PLLCL_OFS_MULT, 8'h00);
        chk("unselected", sfr_rdata, 32'h0);
        check_all(1'b0);
        $display("test registers done");
        @(posedge core_clk);
        ext_ref_khz <= {17'h0, n[14:0]};
        w(PLLCL_OFS_DIVIDER, 8'h05);
        w(PLLCL_OFS_MULT, 8'h14);
        w(PLLCL_OFS_FILTER, 8'h0f);
        w(PLLCL_OFS_CONTROL, 8'h01);
        repeat (500) @(posedge core_clk);
        w(PLLCL_OFS_CONTROL, 8'h03);
        lock_wait();
        check_all(1'b1);
        w(PLLCL_OFS_CONTROL, 8'h07);
        check_all(1'b1);
        w(PLLCL_OFS_CONTROL, 8'h05);
        repeat (2) @(posedge core_clk);
        #1;
        chk("unlock", lock_indicator, 32'h0);
        w(PLLCL_OFS_MULT, 8'h00);
        w(PLLCL_OFS_DIVIDER, 8'h00);
        w(PLLCL_OFS_CONTROL, 8'h03);
        lock_wait();
        check_all(1'b1);
        do_reset();
        check_all(1'b0);
        $display("test lock done");
        final_report();
    end
endmodule : test_pll_config_and_lock_control
